// ==== rtl/ascc_defines.svh ====
// Operation
// - Start byte keeps stored range unchanged
// - Type flag with zero range is mode
// - Every input defaults to single-ended 111
// - Differential 001, 100, 111; others reserved
// - Strobe rises when result is ready
// - Strobe stays low in external clock mode
// - Strobe always driven, never released
// - First high bit when idle starts command
// - Early start after 13, 9, 12 bits
// - Result offset binary, top bit first, falling
// - One configuration register per input
// - One eight-bit operating mode register
// - Conversion only on start byte, current method
// - Master holds select low in external clock
// - External clock samples on 14th falling edge
// - Master keeps serial clock rate constant
// - Acquisition mode: 16 clocks, wait, 16 more
// - Internal mode: 8 clocks, wait, 16 more
// - Mode byte: start, selector, 1, 000
// - Mode selector encodings, 011 and 101 reserved
// - Rising edge sampling; select high ignores link
// - Strobe falls on next start bit edge
`ifndef ASCC_DEFINES_SVH
`define ASCC_DEFINES_SVH
`define ASCC_WORD_W       16
`define ASCC_WORD_BITS    5'd16
`define ASCC_CMD_BITS     4'd8
`define ASCC_CMD_LAST     4'd7
`define ASCC_FALLS_AT_CMD 5'd7
`define ASCC_CH_W         3
`define ASCC_CH_NUM       8
`define ASCC_CFG_W        4
`define ASCC_CFG_DEFAULT  4'h7
`define ASCC_TAIL_MODE    4'h8
`define ASCC_TAIL_START   4'h0
`define ASCC_OPMODE_RST   8'h88
`define ASCC_MODE_EXT_CLK 3'h0
`define ASCC_MODE_EXT_ACQ 3'h1
`define ASCC_MODE_INT_CLK 3'h2
`define ASCC_MODE_RSV_A   3'h3
`define ASCC_MODE_RESET   3'h4
`define ASCC_MODE_RSV_B   3'h5
`define ASCC_MODE_PART_PD 3'h6
`define ASCC_MODE_FULL_PD 3'h7
`define ASCC_EARLY_M0     5'd13
`define ASCC_EARLY_M1     5'd9
`define ASCC_EARLY_M2     5'd12
`define ASCC_SAMPLE_M0    5'd14
`define ASCC_LOAD_M0      5'd16
`define ASCC_ACQ_END_M1   5'd16
`define ASCC_ACQ_END_M2   5'd8
`define ASCC_RNG_SE_BQ    4'h1
`define ASCC_RNG_SE_NH    4'h2
`define ASCC_RNG_SE_PH    4'h3
`define ASCC_RNG_SE_BH    4'h4
`define ASCC_RNG_SE_NF    4'h5
`define ASCC_RNG_SE_PF    4'h6
`define ASCC_RNG_SE_BF    4'h7
`define ASCC_RNG_DF_H     4'h9
`define ASCC_RNG_DF_F     4'hc
`define ASCC_RNG_DF_D     4'hf
`define ASCC_HREG_TX      4'h0
`define ASCC_HREG_STATUS  4'h4
`define ASCC_HREG_RX      4'h8
`define ASCC_TX_BYTE_HI   7
`define ASCC_TX_CLK_HI    13
`define ASCC_TX_CLK_LO    8
`endif

// ==== rtl/ascc_pkg.sv ====
`include "ascc_defines.svh"
package ascc_pkg;
  typedef enum logic [3:0] {
    SPAN_SE_BIP_QUARTER,
    SPAN_SE_NEG_HALF,
    SPAN_SE_POS_HALF,
    SPAN_SE_BIP_HALF,
    SPAN_SE_NEG_FULL,
    SPAN_SE_POS_FULL,
    SPAN_SE_BIP_FULL,
    SPAN_DF_BIP_HALF,
    SPAN_DF_BIP_FULL,
    SPAN_DF_BIP_DOUBLE,
    SPAN_NONE
  } ascc_span_e;

  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_CMD,
    DEV_ACQ,
    DEV_CONV
  } ascc_dev_state_e;

  function automatic ascc_span_e ascc_span_of(input logic [3:0] code);
    case (code)
      `ASCC_RNG_SE_BQ: return SPAN_SE_BIP_QUARTER;
      `ASCC_RNG_SE_NH: return SPAN_SE_NEG_HALF;
      `ASCC_RNG_SE_PH: return SPAN_SE_POS_HALF;
      `ASCC_RNG_SE_BH: return SPAN_SE_BIP_HALF;
      `ASCC_RNG_SE_NF: return SPAN_SE_NEG_FULL;
      `ASCC_RNG_SE_PF: return SPAN_SE_POS_FULL;
      `ASCC_RNG_SE_BF: return SPAN_SE_BIP_FULL;
      `ASCC_RNG_DF_H:  return SPAN_DF_BIP_HALF;
      `ASCC_RNG_DF_F:  return SPAN_DF_BIP_FULL;
      `ASCC_RNG_DF_D:  return SPAN_DF_BIP_DOUBLE;
      default:         return SPAN_NONE;
    endcase
  endfunction : ascc_span_of
endpackage : ascc_pkg

// ==== rtl/ascc_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ascc_link_if;
  logic csN;
  logic sclk;
  logic serialIn;
  logic serialOut;
  logic serialOutEnN;
  logic strobe;
  logic serialOutLine;

  // Released line reads as pulled high
  assign serialOutLine = serialOutEnN ? 1'b1 : serialOut;

  modport dev (
    input  csN,
    input  sclk,
    input  serialIn,
    output serialOut,
    output serialOutEnN,
    output strobe
  );
  modport host (
    output csN,
    output sclk,
    output serialIn,
    input  serialOutLine,
    input  strobe
  );
endinterface : ascc_link_if
`default_nettype wire

// ==== rtl/ascc_device.sv ====
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ascc_defines.svh"
module ascc_device #(
  parameter int CONV_CYCLES = 200
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Serial link
  ascc_link_if.dev                        link,
  // Converter core
  input  wire logic [`ASCC_WORD_W-1:0]    sampleValue,
  output logic                            sampleNow,
  output logic [`ASCC_CH_W-1:0]           sampleChan,
  output ascc_pkg::ascc_span_e            sampleSpan,
  // Operating state
  output logic [2:0]                      modeSel,
  output logic                            partialDown,
  output logic                            fullDown,
  output logic                            convBusy,
  // Configuration view
  input  wire logic [`ASCC_CH_W-1:0]      cfgViewChan,
  output logic [`ASCC_CFG_W-1:0]          cfgView
);
  import ascc_pkg::*;

  localparam int TW = $clog2(CONV_CYCLES);

  // Timer width comes from the count, so tiny or huge counts are refused
  if (CONV_CYCLES < 2 || CONV_CYCLES > 4096) begin : g_conv_check
    $error("CONV_CYCLES out of range");
  end

  typedef struct packed {
    logic                                        csS1;
    logic                                        csS2;
    logic                                        sclkS1;
    logic                                        sclkS2;
    logic                                        sclkS3;
    logic                                        dinS1;
    logic                                        dinS2;
    ascc_dev_state_e                             state;
    logic [7:0]                                  cmdShift;
    logic [3:0]                                  bitCnt;
    logic [4:0]                                  fallCnt;
    logic [TW-1:0]                               timer;
    logic [7:0]                                  opMode;
    logic [`ASCC_CH_NUM-1:0][`ASCC_CFG_W-1:0]    cfg;
    logic [`ASCC_WORD_W-1:0]                     sample;
    logic [`ASCC_WORD_W-1:0]                     resShift;
    logic [4:0]                                  outLeft;
    logic                                        strobe;
    logic                                        sampleNow;
    logic [`ASCC_CH_W-1:0]                       convChan;
    ascc_span_e                                  span;
    logic [`ASCC_CFG_W-1:0]                      cfgView;
  } ascc_dev_s;

  localparam ascc_dev_s RST = '{
    csS1:     1'b1,
    csS2:     1'b1,
    state:    DEV_IDLE,
    opMode:   `ASCC_OPMODE_RST,
    cfg:      {`ASCC_CH_NUM{`ASCC_CFG_DEFAULT}},
    span:     SPAN_SE_BIP_FULL,
    cfgView:  `ASCC_CFG_DEFAULT,
    default:  '0
  };

  ascc_dev_s cur;
  ascc_dev_s next_cur;

  logic                    rise;
  logic                    fall;
  logic [2:0]              mode;
  logic [4:0]              early;
  logic [4:0]              bitsOut;
  logic                    startOk;
  logic [7:0]              byteIn;
  logic [4:0]              fc;
  logic                    convMode;

  always_comb begin
    next_cur = cur;
    next_cur.csS1 = link.csN;
    next_cur.csS2 = cur.csS1;
    next_cur.sclkS1 = link.sclk;
    next_cur.sclkS2 = cur.sclkS1;
    next_cur.sclkS3 = cur.sclkS2;
    next_cur.dinS1 = link.serialIn;
    next_cur.dinS2 = cur.dinS1;
    next_cur.sampleNow = 1'b0;
    next_cur.cfgView = cur.cfg[cfgViewChan];
    // Link activity only counts with select low
    rise = !cur.csS2 && cur.sclkS2 && !cur.sclkS3;
    fall = !cur.csS2 && !cur.sclkS2 && cur.sclkS3;
    mode = cur.opMode[6:4];
    convMode = (mode == `ASCC_MODE_EXT_CLK) ||
               (mode == `ASCC_MODE_EXT_ACQ) ||
               (mode == `ASCC_MODE_INT_CLK);
    case (mode)
      `ASCC_MODE_EXT_ACQ: early = `ASCC_EARLY_M1;
      `ASCC_MODE_INT_CLK: early = `ASCC_EARLY_M2;
      default:            early = `ASCC_EARLY_M0;
    endcase
    bitsOut = `ASCC_WORD_BITS - cur.outLeft;
    startOk = (cur.state == DEV_IDLE) &&
              ((cur.outLeft == 5'd0) || (bitsOut >= early));
    byteIn = {cur.cmdShift[6:0], cur.dinS2};
    fc = cur.fallCnt + 5'd1;

    if (rise) begin
      case (cur.state)
        DEV_IDLE: begin
          if (cur.dinS2 && startOk) begin
            next_cur.state = DEV_CMD;
            next_cur.cmdShift = 8'h01;
            next_cur.bitCnt = 4'h1;
            next_cur.strobe = 1'b0;
          end
        end
        DEV_CMD: begin
          next_cur.cmdShift = byteIn;
          next_cur.bitCnt = cur.bitCnt + 4'h1;
          if (cur.bitCnt == `ASCC_CMD_LAST) begin
            next_cur.state = DEV_IDLE;
            if (byteIn[3:0] == `ASCC_TAIL_MODE) begin
              case (byteIn[6:4])
                `ASCC_MODE_RESET: begin
                  next_cur.opMode = `ASCC_OPMODE_RST;
                  next_cur.cfg = {`ASCC_CH_NUM{`ASCC_CFG_DEFAULT}};
                end
                `ASCC_MODE_RSV_A, `ASCC_MODE_RSV_B: begin
                  next_cur.opMode = cur.opMode;
                end
                default: begin
                  next_cur.opMode = byteIn;
                end
              endcase
            end else if (byteIn[3:0] == `ASCC_TAIL_START) begin
              // Power-down modes take no conversion
              if (convMode) begin
                next_cur.state = DEV_ACQ;
                next_cur.fallCnt = `ASCC_FALLS_AT_CMD;
                next_cur.convChan = byteIn[6:4];
                next_cur.span = ascc_span_of(cur.cfg[byteIn[6:4]]);
              end
            end else if (ascc_span_of(byteIn[3:0]) != SPAN_NONE) begin
              next_cur.cfg[byteIn[6:4]] = byteIn[3:0];
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (fall && cur.outLeft != 5'd0) begin
      next_cur.resShift = {cur.resShift[`ASCC_WORD_W-2:0], 1'b0};
      next_cur.outLeft = cur.outLeft - 5'd1;
    end

    if (cur.state == DEV_ACQ && fall) begin
      next_cur.fallCnt = fc;
      if (mode == `ASCC_MODE_EXT_CLK) begin
        if (fc == `ASCC_SAMPLE_M0) begin
          next_cur.sample = sampleValue;
          next_cur.sampleNow = 1'b1;
        end
        if (fc == `ASCC_LOAD_M0) begin
          // No strobe here: the master is clocking the result out
          next_cur.resShift = cur.sample;
          next_cur.outLeft = `ASCC_WORD_BITS;
          next_cur.state = DEV_IDLE;
        end
      end else if ((mode == `ASCC_MODE_EXT_ACQ && fc == `ASCC_ACQ_END_M1) ||
                   (mode == `ASCC_MODE_INT_CLK && fc == `ASCC_ACQ_END_M2))
      begin
        next_cur.sample = sampleValue;
        next_cur.sampleNow = 1'b1;
        next_cur.timer = '0;
        next_cur.state = DEV_CONV;
      end
    end else if (cur.state != DEV_CONV && cur.csS2) begin
      // Select raised mid-byte or mid-acquisition aborts it
      next_cur.state = DEV_IDLE;
    end

    if (cur.state == DEV_CONV) begin
      next_cur.timer = cur.timer + TW'(1);
      if (cur.timer == TW'(CONV_CYCLES - 1)) begin
        next_cur.resShift = cur.sample;
        next_cur.outLeft = `ASCC_WORD_BITS;
        next_cur.strobe = 1'b1;
        next_cur.state = DEV_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign link.serialOut = cur.resShift[`ASCC_WORD_W-1];
  assign link.serialOutEnN = cur.csS2;
  assign link.strobe = cur.strobe;
  assign sampleNow = cur.sampleNow;
  assign sampleChan = cur.convChan;
  assign sampleSpan = cur.span;
  assign modeSel = cur.opMode[6:4];
  assign partialDown = (cur.opMode[6:4] == `ASCC_MODE_PART_PD);
  assign fullDown = (cur.opMode[6:4] == `ASCC_MODE_FULL_PD);
  assign convBusy = (cur.state == DEV_ACQ) || (cur.state == DEV_CONV);
  assign cfgView = cur.cfgView;
endmodule : ascc_device
`default_nettype wire

// ==== rtl/ascc_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ascc_defines.svh"
module ascc_host #(
  parameter int SCLK_HALF = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData,
  // Serial link
  ascc_link_if.host        link
);
  import ascc_pkg::*;

  localparam int DW = $clog2(SCLK_HALF);

  // Device needs several of its cycles per serial clock phase
  if (SCLK_HALF < 4) begin : g_half_check
    $error("SCLK_HALF must be at least 4");
  end

  typedef struct packed {
    logic            misoS1;
    logic            misoS2;
    logic            strbS1;
    logic            strbS2;
    logic            busy;
    logic            csN;
    logic            sclk;
    logic            mosi;
    logic [7:0]      txShift;
    logic [5:0]      clkLeft;
    logic [DW-1:0]   div;
    logic [31:0]     rx;
    logic [31:0]     rdData;
  } ascc_host_s;

  localparam ascc_host_s RST = '{csN: 1'b1, default: '0};

  ascc_host_s cur;
  ascc_host_s next_cur;
  logic       tick;
  logic [5:0] reqClks;

  always_comb begin
    next_cur = cur;
    next_cur.misoS1 = link.serialOutLine;
    next_cur.misoS2 = cur.misoS1;
    next_cur.strbS1 = link.strobe;
    next_cur.strbS2 = cur.strbS1;
    next_cur.rdData = '0;
    reqClks = regWrData[`ASCC_TX_CLK_HI:`ASCC_TX_CLK_LO];
    tick = cur.busy && (cur.div == DW'(SCLK_HALF - 1));

    if (cur.busy) begin
      next_cur.div = tick ? '0 : cur.div + DW'(1);
    end
    if (tick) begin
      if (!cur.sclk) begin
        if (cur.clkLeft == 6'd0) begin
          next_cur.csN = 1'b1;
          next_cur.busy = 1'b0;
        end else begin
          next_cur.sclk = 1'b1;
          next_cur.rx = {cur.rx[30:0], cur.misoS2};
        end
      end else begin
        next_cur.sclk = 1'b0;
        next_cur.clkLeft = cur.clkLeft - 6'd1;
        next_cur.txShift = {cur.txShift[6:0], 1'b0};
        next_cur.mosi = cur.txShift[6];
      end
    end

    // A new frame is refused while one is running
    if (regWr && regAddr == `ASCC_HREG_TX && !cur.busy &&
        reqClks != 6'd0) begin
      next_cur.busy = 1'b1;
      next_cur.csN = 1'b0;
      next_cur.div = '0;
      next_cur.clkLeft = reqClks;
      next_cur.txShift = regWrData[`ASCC_TX_BYTE_HI:0];
      next_cur.mosi = regWrData[`ASCC_TX_BYTE_HI];
      next_cur.rx = '0;
    end

    if (regRd) begin
      if (regAddr == `ASCC_HREG_STATUS) begin
        next_cur.rdData = {30'h0, cur.strbS2, cur.busy};
      end else if (regAddr == `ASCC_HREG_RX) begin
        next_cur.rdData = cur.rx;
      end else begin
        next_cur.rdData = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign regRdData = cur.rdData;
  assign link.csN = cur.csN;
  assign link.sclk = cur.sclk;
  assign link.serialIn = cur.mosi;
endmodule : ascc_host
`default_nettype wire

// ==== dv/ascc_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module ascc_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Link
  input wire logic       csN,
  input wire logic       sclk,
  input wire logic       serialIn,
  input wire logic       serialOut,
  input wire logic       serialOutEnN,
  input wire logic       strobe,
  // Device state
  input wire logic [2:0] modeSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ext_clk_quiet: assert property (modeSel == 3'h0 |-> !strobe)
    else $error("strobe high in external clock mode");
  a_strobe_rise_mode: assert property (
    $rose(strobe) |-> modeSel inside {3'h1, 3'h2})
    else $error("strobe rose outside timed modes");
  a_strobe_hold_idle: assert property (strobe && csN |=> strobe)
    else $error("strobe dropped while deselected");
  a_strobe_clear_start: assert property (
    $fell(strobe) |-> !csN && sclk && serialIn)
    else $error("strobe fell without a start bit");
  a_dout_release: assert property ($rose(csN) |-> ##[1:4] serialOutEnN)
    else $error("data out not released after deselect");
  // Sclk low lasts 8 clocks, so high now and 6 ago means no fall between
  a_dout_steady: assert property (
    sclk && $past(sclk, 6) && !serialOutEnN |-> $stable(serialOut))
    else $error("data out moved while sclk high");
  a_select_frames: assert property (sclk |-> !csN)
    else $error("sclk toggled with select high");
  a_din_stable: assert property (sclk && $past(sclk) |-> $stable(serialIn))
    else $error("data in moved while sclk high");
  a_mode_legal: assert property (
    $changed(modeSel) |-> !(modeSel inside {3'h3, 3'h4, 3'h5}))
    else $error("mode register took an illegal code");

  c_strobe_rise: cover property ($rose(strobe));
  c_strobe_fall: cover property ($fell(strobe));
  c_mode_change: cover property ($changed(modeSel));
endmodule : ascc_props
`default_nettype wire

// ==== dv/adc_serial_command_control_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ascc_defines.svh"
module adc_serial_command_control_test;
  import ascc_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic [15:0] sampleValue = 16'h0;
  logic [2:0]  cfgViewChan = 3'h0;
  logic [3:0]  cfgView;
  logic        sampleNow;
  logic        convBusy;
  logic        partialDown;
  logic        fullDown;
  logic [2:0]  sampleChan;
  logic [2:0]  modeSel;
  ascc_span_e  sampleSpan;
  logic [31:0] rx;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          nSamples = 0;

  always #10 clk = ~clk;
  always @(posedge clk) if (sampleNow === 1'b1) nSamples++;

  ascc_link_if lnk ();
  ascc_device #(.CONV_CYCLES(8)) ascc_device_inst (
    .clk(clk), .reset_n(reset_n), .link(lnk), .sampleValue(sampleValue),
    .sampleNow(sampleNow), .sampleChan(sampleChan), .sampleSpan(sampleSpan),
    .modeSel(modeSel), .partialDown(partialDown), .fullDown(fullDown),
    .convBusy(convBusy), .cfgViewChan(cfgViewChan), .cfgView(cfgView));
  ascc_host #(.SCLK_HALF(8)) ascc_host_inst (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .link(lnk));
  ascc_props ascc_props_inst (
    .clk(clk), .reset_n(reset_n), .csN(lnk.csN), .sclk(lnk.sclk),
    .serialIn(lnk.serialIn), .serialOut(lnk.serialOut),
    .serialOutEnN(lnk.serialOutEnN), .strobe(lnk.strobe), .modeSel(modeSel));

  task stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask : reg_rd

  task poll(input int b, input logic v);
    logic [31:0] s;
    int          i;
    for (i = 0; i < 400; i++) begin
      reg_rd(`ASCC_HREG_STATUS, s);
      if (s[b] === v) break;
    end
    if (i == 400) begin
      chk(1'b0, "wait ran out");
      stop_test();
    end
  endtask : poll

  task xfer(input logic [7:0] b, input logic [5:0] n);
    reg_wr(`ASCC_HREG_TX, {18'h0, n, b});
    poll(0, 1'b0);
    reg_rd(`ASCC_HREG_RX, rx);
  endtask : xfer

  task cfg_is(input logic [2:0] ch, input logic [3:0] e);
    @(posedge clk);
    cfgViewChan <= ch;
    @(posedge clk);
    @(negedge clk);
    chk(cfgView === e, "stored configuration");
  endtask : cfg_is

  task t_reset;
    for (int c = 0; c < 8; c++) cfg_is(3'(c), `ASCC_CFG_DEFAULT);
    chk(modeSel === 3'h0 && lnk.strobe === 1'b0, "reset mode");
    chk(lnk.serialOutLine === 1'b1, "data out released");
    reg_rd(4'hc, rx);
    chk(rx === 32'h0, "unmapped read");
    $display("reset test done");
  endtask : t_reset

  task t_ext_clock;
    int n0;
    xfer(8'ha3, 6'd8);
    cfg_is(3'h2, 4'h3);
    @(posedge clk);
    sampleValue <= 16'hb5a3;
    n0 = nSamples;
    xfer(8'ha0, 6'd32);
    chk(rx[15:0] === 16'hb5a3, "mode 0 result");
    chk(nSamples === n0 + 1, "one sample");
    chk(sampleChan === 3'h2, "channel");
    chk(sampleSpan === SPAN_SE_POS_HALF, "span");
    cfg_is(3'h2, 4'h3);
    reg_rd(`ASCC_HREG_STATUS, rx);
    chk(rx[1] === 1'b0, "strobe in mode 0");
    $display("external clock test done");
  endtask : t_ext_clock

  task t_config;
    logic [3:0] good [9];
    logic [3:0] bad [4];
    good = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hc, 4'hf};
    bad = '{4'ha, 4'hb, 4'hd, 4'he};
    for (int i = 0; i < 9; i++) begin
      xfer({1'b1, 3'(i), good[i]}, 6'd8);
      cfg_is(3'(i), good[i]);
    end
    for (int i = 0; i < 4; i++) begin
      xfer({4'hd, bad[i]}, 6'd8);
      cfg_is(3'h5, 4'h6);
      chk(convBusy === 1'b0, "reserved code converts");
    end
    $display("configuration test done");
  endtask : t_config

  // Readout cut one bit short of, then exactly at, the early-start point
  task t_early;
    @(posedge clk);
    sampleValue <= 16'h9e71;
    xfer(8'ha0, 6'd28);
    chk(rx[11:0] === 12'h9e7, "partial result");
    xfer(8'hb6, 6'd8);
    cfg_is(3'h3, 4'h4);
    xfer(8'ha0, 6'd29);
    chk(rx[12:0] === 13'h13ce, "partial result");
    xfer(8'hb6, 6'd8);
    cfg_is(3'h3, 4'h6);
    $display("early start test done");
  endtask : t_early

  task t_modes;
    for (int m = 1; m <= 2; m++) begin
      xfer({1'b1, 3'(m), 4'h8}, 6'd8);
      chk(modeSel === 3'(m), "mode register");
      @(posedge clk);
      sampleValue <= {3'(m), 13'h0c3e};
      xfer(8'h90, (m == 1) ? 6'd16 : 6'd8);
      poll(1, 1'b1);
      xfer(8'h00, 6'd16);
      chk(rx[15:0] === {3'(m), 13'h0c3e}, "timed result");
      reg_rd(`ASCC_HREG_STATUS, rx);
      chk(rx[1] === 1'b1, "strobe held");
    end
    xfer(8'h88, 6'd8);
    reg_rd(`ASCC_HREG_STATUS, rx);
    chk(rx[1] === 1'b0 && modeSel === 3'h0, "strobe cleared");
    $display("timed modes test done");
  endtask : t_modes

  task t_power;
    int n0;
    xfer(8'hb8, 6'd8);
    chk(modeSel === 3'h0, "reserved mode taken");
    xfer(8'hd8, 6'd8);
    chk(modeSel === 3'h0, "reserved mode taken");
    xfer(8'he8, 6'd8);
    chk(partialDown === 1'b1 && modeSel === 3'h6, "partial down");
    n0 = nSamples;
    xfer(8'ha0, 6'd32);
    chk(nSamples === n0 && convBusy === 1'b0, "converted asleep");
    xfer(8'hf8, 6'd8);
    chk(fullDown === 1'b1, "full down");
    xfer(8'hc8, 6'd8);
    chk(modeSel === 3'h0, "reset mode");
    cfg_is(3'h2, `ASCC_CFG_DEFAULT);
    $display("power test done");
  endtask : t_power

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_ext_clock();
    t_config();
    t_early();
    t_modes();
    t_power();
    stop_test();
  end
endmodule : adc_serial_command_control_test
`default_nettype wire
